/* File: bench/pmr_link_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module pmr_link_monitor (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   // link wires
   input wire logic scl,
   input wire logic host_sda_oe_n,
   input wire logic dev_sda_oe_n,
   input wire logic sda
);
   // ------------------------------------------------------------
   // framing events, judged with the clock held high
   // ------------------------------------------------------------
   default clocking @(posedge sys_clk_in);
   endclocking
   default disable iff (!resetn_in);
   sequence start_seq;
      scl && $past(scl) && $fell(sda);
   endsequence
   sequence stop_seq;
      scl && $past(scl) && $rose(sda);
   endsequence
   // quarter of 4 cycles assumed: high phase is two quarters
   dev_quiet_a: assert property (scl && !host_sda_oe_n |-> dev_sda_oe_n)
      else $error("device drove while host drives");
   dev_edge_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
      else $error("device moved data with clock high");
   addr_quiet_a: assert property (start_seq |-> dev_sda_oe_n [*8])
      else $error("device drove during address");
   host_yield_a: assert property (scl && !dev_sda_oe_n |-> host_sda_oe_n)
      else $error("host drove while device drives");
   stop_idle_a: assert property (stop_seq |-> (scl && dev_sda_oe_n) [*8])
      else $error("bus not idle after stop");
   ack_hold_a: assert property ($fell(dev_sda_oe_n) |-> !dev_sda_oe_n [*8])
      else $error("device low bit too short");
   scl_high_a: assert property ($rose(scl) |-> scl [*8])
      else $error("clock high phase wrong");
   scl_low_a: assert property ($fell(scl) |-> !scl [*4])
      else $error("clock low phase short");
endmodule
`default_nettype wire

/* File: bench/power_monitor_readback_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module power_monitor_readback_tb;
   import pmr_pkg::*;
   // ------------------------------------------------------------
   // stimulus and wiring
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic req = 1'b0;
   logic [1:0] nb = 2'h0;
   logic busy, done, refused, alert_n, once, sw, dsel;
   logic [23:0] data;
   logic [7:0] st;
   logic cv = 1'b0;
   logic [11:0] vc = 12'h000;
   logic [11:0] ic = 12'h000;
   logic [7:0] val = 8'h00;
   logic [3:0] wr = 4'h0;
   logic on = 1'b1;
   logic fault = 1'b0;
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;
   pmr_link_if link();
   always #5 clk = ~clk;
   // small quarter keeps a three-byte frame near 600 cycles
   pmr_host #(.TICK_CYCLES(4)) i_pmr_host (.sys_clk_in(clk), .resetn_in(rstn),
      .link(link.host), .read_req_in(req), .read_bytes_in(nb), .busy_out(busy),
      .done_out(done), .refused_out(refused), .data_out(data));
   pmr_device i_pmr_device (.sys_clk_in(clk), .resetn_in(rstn), .link(link.dev),
      .conv_valid_in(cv), .v_code_in(vc), .i_code_in(ic), .cmd_wr_in(wr[0]),
      .cmd_in(val[6:0]), .alert_en_wr_in(wr[1]), .alert_en_in(val[4:0]),
      .limit_wr_in(wr[2]), .current_alert_limit_in(val), .ctrl_wr_in(wr[3]),
      .ctrl_in(val[0:0]), .on_in(on), .swap_fault_in(fault),
      .swap_overcurrent_live_in(1'b0), .alert_out_n_oe_n_out(alert_n),
      .alert_status_out(st), .once_busy_out(once), .software_shutdown_out(sw),
      .divider_select_out(dsel));
   pmr_link_monitor i_pmr_link_monitor (.sys_clk_in(clk), .resetn_in(rstn),
      .scl(link.scl), .host_sda_oe_n(link.host_sda_oe_n),
      .dev_sda_oe_n(link.dev_sda_oe_n), .sda(link.sda));
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // sample just after the edge so its updates have landed
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // sel: 0 command, 1 alert enable, 2 limit, 3 control
   task automatic cfg(input int sel, input logic [7:0] v);
      @(posedge clk);
      val <= v;
      wr <= 4'h1 << sel;
      @(posedge clk);
      wr <= 4'h0;
      tick(3);
   endtask
   task automatic conv(input logic [11:0] v, input logic [11:0] i);
      @(posedge clk);
      cv <= 1'b1;
      vc <= v;
      ic <= i;
      @(posedge clk);
      cv <= 1'b0;
      tick(3);
   endtask
   // upper bytes are zeroed at each request; only the read bytes are compared
   task automatic rd(input logic [1:0] n, input logic ref_exp, input logic [23:0] exp);
      int k;
      logic [23:0] m;
      m = (n == 2'h3) ? 24'hffffff : (n == 2'h2) ? 24'h00ffff : 24'h0000ff;
      @(posedge clk);
      req <= 1'b1;
      nb <= n;
      @(posedge clk);
      req <= 1'b0;
      tick(0);
      check("busy", {23'h0, busy}, 24'h1);
      for (k = 0; k < 2000 && done !== 1'b1; k++) tick(1);
      check("done", {23'h0, done}, 24'h1);
      check("refused", {23'h0, refused}, {23'h0, ref_exp});
      if (!ref_exp) check("data", data & m, exp);
   endtask
   task automatic stat(input logic [7:0] s, input logic a);
      check("status", {16'h0, st}, {16'h0, s});
      check("alert", {23'h0, alert_n}, {23'h0, a});
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_data();
      cfg(0, 8'h15);
      check("range", {23'h0, dsel}, 24'h1);
      rd(3, 1'b0, 24'h000000);
      conv(12'habc, 12'h123);
      rd(3, 1'b0, 24'hab12c3);
      check("vcode", {12'h0, data[23:16], data[7:4]}, 24'h000abc);
      check("icode", {12'h0, data[15:8], data[3:0]}, 24'h000123);
      cfg(0, 8'h01);
      rd(2, 1'b0, 24'h00abc0);
      cfg(0, 8'h04);
      // a conversion landing mid-read must not reach the frozen bytes
      fork
         rd(2, 1'b0, 24'h001230);
         begin
            tick(200);
            conv(12'hfff, 12'hfff);
         end
      join
      $display("test data formats done");
   endtask
   task automatic t_once();
      cfg(0, 8'h02);
      check("once", {23'h0, once}, 24'h1);
      rd(2, 1'b1, 24'h0);
      conv(12'h5a5, 12'h000);
      check("once", {23'h0, once}, 24'h0);
      rd(2, 1'b0, 24'h005a50);
      $display("test single conversion done");
   endtask
   task automatic t_trip();
      int k;
      cfg(2, 8'h10);
      cfg(1, 8'h01);
      conv(12'h000, 12'h200);
      stat(8'h03, 1'b0);
      cfg(0, 8'h40);
      rd(1, 1'b0, 24'h000003);
      cfg(1, 8'h10);
      stat(8'h01, 1'b1);
      for (k = 0; k < 3; k++) begin
         conv(12'h000, 12'h10f);
         check("seen", {23'h0, st[0]}, {23'h0, k < 2});
      end
      $display("test current trip done");
   endtask
   task automatic t_off();
      cfg(1, 8'h0c);
      @(posedge clk);
      on <= 1'b0;
      fault <= 1'b1;
      @(posedge clk);
      fault <= 1'b0;
      tick(3);
      stat(8'h3c, 1'b0);
      @(posedge clk);
      on <= 1'b1;
      tick(3);
      cfg(3, 8'h01);
      check("software_shutdown", {23'h0, sw}, 24'h1);
      cfg(1, 8'h1c);
      stat(8'h10, 1'b1);
      cfg(3, 8'h00);
      check("software_shutdown", {23'h0, sw}, 24'h0);
      stat(8'h00, 1'b1);
      rd(1, 1'b0, 24'h000000);
      $display("test shutdown and fault done");
   endtask
   // ------------------------------------------------------------
   // run control
   // ------------------------------------------------------------
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      tick(2);
      stat(8'h00, 1'b1);
      t_data();
      t_once();
      t_trip();
      t_off();
      tally_and_finish();
   end
   // eight frames of at most about 600 cycles, so 20000 is ample
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end
endmodule
`default_nettype wire

/* File: hw/pmr_device.sv */
`timescale 1ns/1ps
`default_nettype none
module pmr_device
   import pmr_pkg::*;
#(
   parameter logic [6:0] OWN_ADDR = DEV_ADDR,
   parameter bit LATCH_OFF = 1'b1
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   // link
   pmr_link_if.dev link,
   // conversion results
   input wire logic conv_valid_in,
   input wire logic [11:0] v_code_in,
   input wire logic [11:0] i_code_in,
   // configuration writes
   input wire logic cmd_wr_in,
   input wire logic [6:0] cmd_in,
   input wire logic alert_en_wr_in,
   input wire logic [4:0] alert_en_in,
   input wire logic limit_wr_in,
   input wire logic [7:0] current_alert_limit_in,
   input wire logic ctrl_wr_in,
   input wire logic [0:0] ctrl_in,
   // hot swap state
   input wire logic on_in,
   input wire logic swap_fault_in,
   input wire logic swap_overcurrent_live_in,
   // outputs
   output logic alert_out_n_oe_n_out,
   output logic [7:0] alert_status_out,
   output logic once_busy_out,
   output logic software_shutdown_out,
   output logic divider_select_out
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      D_IDLE = 5'h01, D_ADDR = 5'h02, D_AACK = 5'h04, D_TX = 5'h08, D_RACK = 5'h10
   } pmr_dev_e;

   typedef struct packed {
      pmr_dev_e st;
      logic [3:0] bitc;
      logic [7:0] sh;
      logic [1:0] idx;
      logic [1:0] nbytes;
      logic acked;
      logic scl_p;
      logic sda_p;
      logic sda_oe_n;
      logic [23:0] snap;
      logic [11:0] v;
      logic [11:0] i;
      logic have_conv;
      logic pend;
      logic [6:0] cmd;
      logic [3:0] aen;
      logic [7:0] limit;
      logic software_shutdown;
      logic [2:0] hist;
      logic [2:0] run;
      logic off_p;
      logic [7:0] status;
      logic alert_oe_n;
   } pmr_dev_s;

   pmr_dev_s q, d;

   // ------------------------------------------------------------
   // packing of the readback bytes
   // ------------------------------------------------------------
   function automatic logic [23:0] pack_bytes(input logic [6:0] cmd, input logic [7:0] st,
                                              input logic [11:0] v, input logic [11:0] i);
      logic v_sel;
      logic i_sel;
      v_sel = cmd[CMD_V_CONT] | cmd[CMD_V_ONCE];
      i_sel = cmd[CMD_I_CONT] | cmd[CMD_I_ONCE];
      if (cmd[CMD_STATUS_RD]) begin
         pack_bytes = {st, 16'h0000};
      end else if (i_sel && !v_sel) begin
         pack_bytes = {i[11:4], i[3:0], 4'h0, 8'h00};
      end else if (v_sel && !i_sel) begin
         pack_bytes = {v[11:4], v[3:0], 4'h0, 8'h00};
      end else begin
         pack_bytes = {v[11:4], i[11:4], v[3:0], i[3:0]};
      end
   endfunction

   function automatic logic [1:0] byte_count(input logic [6:0] cmd);
      logic v_sel;
      logic i_sel;
      v_sel = cmd[CMD_V_CONT] | cmd[CMD_V_ONCE];
      i_sel = cmd[CMD_I_CONT] | cmd[CMD_I_ONCE];
      if (cmd[CMD_STATUS_RD]) begin
         byte_count = 2'h1;
      end else if (v_sel ^ i_sel) begin
         byte_count = 2'h2;
      end else begin
         byte_count = 2'h3;
      end
   endfunction

   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic exceed;
   logic oc_trip;
   logic off_now;
   logic clear_req;
   logic [7:0] cur_byte;

   // line events, inputs are synchronous to the clock
   assign scl_rise = link.scl & ~q.scl_p;
   assign scl_fall = ~link.scl & q.scl_p;
   assign start_seen = link.scl & q.scl_p & q.sda_p & ~link.sda;
   assign stop_seen = link.scl & q.scl_p & ~q.sda_p & link.sda;
   assign exceed = i_code_in[11:4] > q.limit;
   assign oc_trip = conv_valid_in & exceed &
                    (q.aen[AEN_OC_ONE] | (q.aen[AEN_OC_FOUR] & (q.run >= OC_RUN_TRIP - 3'h1)));
   assign off_now = ~on_in | q.software_shutdown;
   assign clear_req = alert_en_wr_in & alert_en_in[AEN_CLEAR];
   assign cur_byte = (q.idx == 2'h0) ? q.snap[23:16] :
                     (q.idx == 2'h1) ? q.snap[15:8] : q.snap[7:0];

   // ------------------------------------------------------------
   // link slave, status and alert
   // ------------------------------------------------------------
   always_comb begin
      d = q;
      d.scl_p = link.scl;
      d.sda_p = link.sda;

      // configuration; once bits are kept as a pending request
      if (cmd_wr_in) begin
         d.cmd = cmd_in;
         if (cmd_in[CMD_V_ONCE] || cmd_in[CMD_I_ONCE]) begin
            d.pend = 1'b1;
         end
      end
      if (alert_en_wr_in) begin
         d.aen = alert_en_in[3:0];
      end
      if (limit_wr_in) begin
         d.limit = current_alert_limit_in;
      end
      if (ctrl_wr_in) begin
         d.software_shutdown = ctrl_in[CTRL_SOFTWARE_SHUTDOWN];
      end

      // conversion capture; a new once request in the same cycle wins
      if (conv_valid_in) begin
         d.v = v_code_in;
         d.i = i_code_in;
         d.have_conv = 1'b1;
         d.hist = {q.hist[1:0], exceed};
         d.run = exceed ? ((q.run == OC_RUN_TRIP) ? q.run : q.run + 3'h1) : 3'h0;
         // only the request clears; the once bits still pick the readback format
         if (!(cmd_wr_in && (cmd_in[CMD_V_ONCE] || cmd_in[CMD_I_ONCE]))) begin
            d.pend = 1'b0;
         end
      end

      // status: latches set over clear, so no event is lost
      d.off_p = off_now;
      d.status[ST_OC_NOW] = |q.hist;
      d.status[ST_OFF_NOW] = off_now;
      d.status[ST_SWAP_OFF] = LATCH_OFF ? (q.status[ST_SWAP_FAULT] & q.aen[AEN_SWAP])
                                        : swap_overcurrent_live_in;
      d.status[ST_OC_LATCH] = oc_trip | (q.status[ST_OC_LATCH] & ~clear_req);
      d.status[ST_SWAP_FAULT] = swap_fault_in | (q.status[ST_SWAP_FAULT] & ~clear_req);
      d.status[ST_OFF_LATCH] = (off_now & ~q.off_p) |
                               (q.status[ST_OFF_LATCH] & ~clear_req);
      d.status[7:6] = 2'h0;
      d.alert_oe_n = ~((q.status[ST_OC_LATCH] & (q.aen[AEN_OC_ONE] | q.aen[AEN_OC_FOUR])) |
                       (q.status[ST_SWAP_FAULT] & q.aen[AEN_SWAP]) |
                       (q.status[ST_OFF_LATCH] & q.aen[AEN_OFF]));

      // link slave; start and stop override any state
      if (start_seen) begin
         d.st = D_ADDR;
         d.bitc = 4'h0;
         d.sda_oe_n = 1'b1;
      end else if (stop_seen) begin
         d.st = D_IDLE;
         d.sda_oe_n = 1'b1;
      end else begin
         case (q.st)
            D_IDLE: begin
               d.sda_oe_n = 1'b1;
            end
            D_ADDR: begin
               if (scl_rise) begin
                  d.sh = {q.sh[6:0], link.sda};
                  d.bitc = q.bitc + 4'h1;
               end else if (scl_fall && q.bitc == 4'h8) begin
                  // data reads are refused while a single conversion runs
                  if (q.sh[7:1] == OWN_ADDR && q.sh[0] &&
                      !(q.pend && !q.cmd[CMD_STATUS_RD])) begin
                     d.st = D_AACK;
                     d.sda_oe_n = 1'b0;
                     d.idx = 2'h0;
                     d.nbytes = byte_count(q.cmd);
                     // frozen here so one transfer is one conversion; zeros
                     d.snap = pack_bytes(q.cmd, q.status, q.have_conv ? q.v : 12'h000,
                                         q.have_conv ? q.i : 12'h000);
                  end else begin
                     d.st = D_IDLE;
                  end
               end
            end
            D_AACK: begin
               if (scl_fall) begin
                  d.st = D_TX;
                  d.bitc = 4'h0;
                  d.sh = cur_byte;
                  d.sda_oe_n = cur_byte[7];
               end
            end
            D_TX: begin
               if (scl_rise) begin
                  d.bitc = q.bitc + 4'h1;
               end else if (scl_fall) begin
                  if (q.bitc == 4'h8) begin
                     d.st = D_RACK;
                     d.sda_oe_n = 1'b1;
                  end else begin
                     d.sh = {q.sh[6:0], 1'b0};
                     d.sda_oe_n = q.sh[6];
                  end
               end
            end
            D_RACK: begin
               if (scl_rise) begin
                  d.acked = ~link.sda;
               end else if (scl_fall) begin
                  // a nack or the last byte ends the transfer
                  if (q.acked && (q.idx + 2'h1 < q.nbytes)) begin
                     d.idx = q.idx + 2'h1;
                     d.st = D_TX;
                     d.bitc = 4'h0;
                     d.sh = (q.idx == 2'h0) ? q.snap[15:8] : q.snap[7:0];
                     d.sda_oe_n = (q.idx == 2'h0) ? q.snap[15] : q.snap[7];
                  end else begin
                     d.st = D_IDLE;
                  end
               end
            end
            default: begin
               d.st = D_IDLE;
               d.sda_oe_n = 1'b1;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         q <= '{st: D_IDLE, bitc: 4'h0, sh: 8'h00, idx: 2'h0, nbytes: 2'h0, acked: 1'b0,
                scl_p: 1'b1, sda_p: 1'b1, sda_oe_n: 1'b1, snap: 24'h000000, v: 12'h000,
                i: 12'h000, have_conv: 1'b0, pend: 1'b0, cmd: CMD_RESET, aen: AEN_RESET,
                limit: LIMIT_RESET, software_shutdown: 1'b0, hist: 3'h0, run: 3'h0, off_p: 1'b0,
                status: STATUS_RESET, alert_oe_n: 1'b1};
      end else begin
         q <= d;
      end
   end

   assign link.dev_sda_oe_n = q.sda_oe_n;
   assign alert_out_n_oe_n_out = q.alert_oe_n;
   assign alert_status_out = q.status;
   assign once_busy_out = q.pend;
   assign software_shutdown_out = q.software_shutdown;
   assign divider_select_out = q.cmd[CMD_DIV_SEL];
endmodule
`default_nettype wire

/* File: hw/pmr_host.sv */
`timescale 1ns/1ps
`default_nettype none
module pmr_host
   import pmr_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = QUARTER_CYCLES,
   parameter logic [6:0] TARGET_ADDR = DEV_ADDR
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   // link
   pmr_link_if.host link,
   // user side
   input wire logic read_req_in,
   input wire logic [1:0] read_bytes_in,
   output logic busy_out,
   output logic done_out,
   output logic refused_out,
   output logic [23:0] data_out
);
   // the quarter counter is eight bits and needs at least two states
   if (TICK_CYCLES < 2 || TICK_CYCLES > 255) begin : g_tick_check
      $error("pmr_host: TICK_CYCLES out of range");
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum logic [6:0] {
      H_IDLE = 7'h01, H_START = 7'h02, H_ADDR = 7'h04, H_AACK = 7'h08,
      H_READ = 7'h10, H_MACK = 7'h20, H_STOP = 7'h40
   } pmr_hst_e;

   typedef struct packed {
      pmr_hst_e st;
      logic [7:0] tick;
      logic [1:0] ph;
      logic [2:0] bitc;
      logic [7:0] sh;
      logic [1:0] left;
      logic [23:0] data;
      logic scl;
      logic sda_oe_n;
      logic busy;
      logic done;
      logic refused;
   } pmr_hst_s;

   pmr_hst_s q, d;
   logic step;

   // quarter-bit enable from the divider
   assign step = (q.tick == 8'(TICK_CYCLES - 1));

   // ------------------------------------------------------------
   // bit sequencer, four quarters per bit
   // ------------------------------------------------------------
   always_comb begin
      d = q;
      d.done = 1'b0;
      d.tick = (q.st == H_IDLE || step) ? 8'h00 : q.tick + 8'h01;
      case (q.st)
         H_IDLE: begin
            if (read_req_in) begin
               d.st = H_START;
               d.ph = 2'h0;
               d.busy = 1'b1;
               d.refused = 1'b0;
               d.data = 24'h000000;
               d.left = (read_bytes_in == 2'h0) ? 2'h1 : read_bytes_in;
               d.sh = {TARGET_ADDR, 1'b1};
            end
         end
         H_START: begin
            if (step) begin
               d.ph = q.ph + 2'h1;
               if (q.ph == 2'h0) begin
                  d.scl = 1'b1;
                  d.sda_oe_n = 1'b1;
               end else if (q.ph == 2'h1) begin
                  d.sda_oe_n = 1'b0;
               end else if (q.ph == 2'h2) begin
                  d.scl = 1'b0;
               end else begin
                  d.st = H_ADDR;
                  d.bitc = 3'h0;
               end
            end
         end
         H_STOP: begin
            if (step) begin
               d.ph = q.ph + 2'h1;
               if (q.ph == 2'h0) begin
                  d.sda_oe_n = 1'b0;
               end else if (q.ph == 2'h1) begin
                  d.scl = 1'b1;
               end else if (q.ph == 2'h2) begin
                  d.sda_oe_n = 1'b1;
               end else begin
                  d.st = H_IDLE;
                  d.busy = 1'b0;
                  d.done = 1'b1;
               end
            end
         end
         H_ADDR, H_AACK, H_READ, H_MACK: begin
            if (step) begin
               d.ph = q.ph + 2'h1;
               if (q.ph == 2'h0) begin
                  // data only changes while the clock is low
                  if (q.st == H_ADDR) begin
                     d.sda_oe_n = q.sh[7];
                  end else if (q.st == H_MACK) begin
                     d.sda_oe_n = (q.left == 2'h1);
                  end else begin
                     d.sda_oe_n = 1'b1;
                  end
               end else if (q.ph == 2'h1) begin
                  d.scl = 1'b1;
               end else if (q.ph == 2'h2) begin
                  if (q.st == H_AACK) begin
                     d.refused = link.sda;
                  end else if (q.st == H_READ) begin
                     d.sh = {q.sh[6:0], link.sda};
                  end else if (q.st == H_ADDR) begin
                     d.sh = {q.sh[6:0], 1'b0};
                  end
               end else begin
                  d.scl = 1'b0;
                  d.bitc = q.bitc + 3'h1;
                  if (q.st == H_ADDR && q.bitc == 3'h7) begin
                     d.st = H_AACK;
                  end else if (q.st == H_AACK) begin
                     d.st = q.refused ? H_STOP : H_READ;
                     d.bitc = 3'h0;
                  end else if (q.st == H_READ && q.bitc == 3'h7) begin
                     d.st = H_MACK;
                     d.data = {q.data[15:0], q.sh};
                  end else if (q.st == H_MACK) begin
                     d.left = q.left - 2'h1;
                     d.bitc = 3'h0;
                     d.st = (q.left == 2'h1) ? H_STOP : H_READ;
                  end
               end
            end
         end
         default: begin
            d.st = H_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         q <= '{st: H_IDLE, tick: 8'h00, ph: 2'h0, bitc: 3'h0, sh: 8'h00, left: 2'h0,
                data: 24'h000000, scl: 1'b1, sda_oe_n: 1'b1, busy: 1'b0, done: 1'b0,
                refused: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign link.scl = q.scl;
   assign link.host_sda_oe_n = q.sda_oe_n;
   assign busy_out = q.busy;
   assign done_out = q.done;
   assign refused_out = q.refused;
   assign data_out = q.data;
endmodule
`default_nettype wire

/* File: shared/pmr_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pmr_link_if;
   // ------------------------------------------------------------
   // two-wire link, open-drain data resolved here
   // ------------------------------------------------------------
   logic scl;
   logic host_sda_oe_n;
   logic dev_sda_oe_n;
   logic sda;
   // wired-and: any end with its enable low pulls the line low
   assign sda = host_sda_oe_n & dev_sda_oe_n;
   modport host (output scl, output host_sda_oe_n, input sda);
   modport dev (input scl, input sda, output dev_sda_oe_n);
endinterface
`default_nettype wire

/* File: shared/pmr_pkg.sv */
`default_nettype none
package pmr_pkg;
   // ------------------------------------------------------------
   // clocking and link pacing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned LINK_RATE_HZ = 400_000;
   // quarter of a link bit, least time, so rounded up
   localparam int unsigned QUARTER_CYCLES = (CLK_HZ + 4 * LINK_RATE_HZ - 1) / (4 * LINK_RATE_HZ);
   // device address, value arbitrary
   localparam logic [6:0] DEV_ADDR = 7'h2a;

   // ------------------------------------------------------------
   // command field positions
   // ------------------------------------------------------------
   localparam int CMD_V_CONT = 0;
   localparam int CMD_V_ONCE = 1;
   localparam int CMD_I_CONT = 2;
   localparam int CMD_I_ONCE = 3;
   localparam int CMD_DIV_SEL = 4;
   localparam int CMD_STATUS_RD = 6;
   localparam logic [6:0] CMD_RESET = 7'h00;

   // ------------------------------------------------------------
   // alert enable fields
   // ------------------------------------------------------------
   localparam int AEN_OC_ONE = 0;
   localparam int AEN_OC_FOUR = 1;
   localparam int AEN_SWAP = 2;
   localparam int AEN_OFF = 3;
   localparam int AEN_CLEAR = 4;
   localparam logic [3:0] AEN_RESET = 4'h4;
   localparam logic [7:0] LIMIT_RESET = 8'hff;
   localparam int CTRL_SOFTWARE_SHUTDOWN = 0;

   // ------------------------------------------------------------
   // alert_status bits
   // ------------------------------------------------------------
   localparam int ST_OC_NOW = 0;
   localparam int ST_OC_LATCH = 1;
   localparam int ST_SWAP_OFF = 2;
   localparam int ST_SWAP_FAULT = 3;
   localparam int ST_OFF_NOW = 4;
   localparam int ST_OFF_LATCH = 5;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [2:0] OC_RUN_TRIP = 3'h4;
endpackage
`default_nettype wire
